// file: bench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import wakeup_compare_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        mclk_i = 0;
  logic        reset_i = 1;
  logic        restore = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [9:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0]  pstrb = '0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        vld [3] = '{0, 0, 0};
  logic [7:0]  res_v [3] = '{0, 0, 0};
  logic        amplitude_wake_irq_o;
  logic        phase_wake_irq_o;
  logic        capacitance_wake_irq_o;
  logic [7:0]  m_cfg [3];
  logic [7:0]  m_ref [3];
  logic [7:0]  m_avg [3];
  logic [7:0]  m_res [3];
  logic [2:0]  m_en;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;

  always #50 mclk_i = ~mclk_i;

  wakeup_measurement_compare_regs u_wakeup_measurement_compare_regs (
    .mclk_i(mclk_i), .reset_i(reset_i), .restore_defaults_i(restore),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .amplitude_valid_i(vld[0]), .amplitude_result_i(res_v[0]),
    .phase_valid_i(vld[1]), .phase_result_i(res_v[1]),
    .capacitance_valid_i(vld[2]), .capacitance_result_i(res_v[2]),
    .amplitude_wake_irq_o(amplitude_wake_irq_o), .phase_wake_irq_o(phase_wake_irq_o),
    .capacitance_wake_irq_o(capacitance_wake_irq_o));

  // ----------------------------------------------------------------
  // Checking and reporting
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles > 30000) begin
      num_errors++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Expected behaviour
  // ----------------------------------------------------------------
  function automatic logic exp_trig(logic [7:0] c, logic [7:0] r, logic [7:0] rf);
    int d;
    d = int'(r) - int'(rf);
    if (d < 0) d = -d;
    return d > int'(c[7:4]);
  endfunction : exp_trig

  function automatic logic [7:0] exp_avg(logic [7:0] c, logic [7:0] r, logic [7:0] a);
    int d;
    d = int'(r) - int'(a);
    return 8'(int'(a) + (d >>> (int'(c[2:1]) + 2)));
  endfunction : exp_avg

  // ----------------------------------------------------------------
  // Bus and measurement tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     input logic [3:0] strb, output logic [31:0] rd, output logic err);
    @(posedge mclk_i);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= wd; pstrb <= strb;
    @(posedge mclk_i);
    penable <= 1;
    do begin
      @(posedge mclk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel <= 0; penable <= 0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1, idx, {24'h0, d}, 4'hf, rd, err);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [32:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(0, idx, 32'h0, 4'h0, rd, err);
    check(nm, {err, rd}, exp);
  endtask : rd_chk

  task automatic all_chk();
    for (int c = 0; c < NCH; c++) begin
      rd_chk("cfg", CFG_IDX[c], {25'h0, m_cfg[c]});
      rd_chk("ref", REF_IDX[c], {25'h0, m_ref[c]});
      rd_chk("avg", AVG_IDX[c], {25'h0, m_avg[c]});
      rd_chk("res", RES_IDX[c], {25'h0, m_res[c]});
    end
    rd_chk("wake_en", IDX_WAKE_EN, {30'h0, m_en});
  endtask : all_chk

  task automatic clr_model();
    for (int c = 0; c < NCH; c++) begin
      m_cfg[c] = 0; m_ref[c] = 0; m_avg[c] = 0; m_res[c] = 0;
    end
    m_en = 0;
  endtask : clr_model

  task automatic set_ch(input int ch, input logic [7:0] c, input logic [7:0] rf, input logic en);
    m_cfg[ch] = c; m_ref[ch] = rf; m_en[ch] = en;
    wr(CFG_IDX[ch], c);
    wr(REF_IDX[ch], rf);
    wr(IDX_WAKE_EN, {5'h0, m_en});
  endtask : set_ch

  task automatic do_meas(input int ch, input logic [7:0] r);
    logic [7:0] rf;
    logic       t;
    rf = m_cfg[ch][REFSEL_BIT] ? m_avg[ch] : m_ref[ch];
    t = m_en[ch] && exp_trig(m_cfg[ch], r, rf);
    @(posedge mclk_i);
    vld[ch] <= 1; res_v[ch] <= r;
    @(posedge mclk_i);
    vld[ch] <= 0;
    #1;
    check("irq", {capacitance_wake_irq_o, phase_wake_irq_o, amplitude_wake_irq_o},
          33'(t) << ch);
    m_res[ch] = r;
    if (m_en[ch] && (!t || m_cfg[ch][INCLUDE_BIT])) m_avg[ch] = exp_avg(m_cfg[ch], r, m_avg[ch]);
    @(posedge mclk_i);
    #1;
    check("irq_end", {capacitance_wake_irq_o, phase_wake_irq_o, amplitude_wake_irq_o}, 0);
    rd_chk("res", RES_IDX[ch], {25'h0, m_res[ch]});
    rd_chk("avg", AVG_IDX[ch], {25'h0, m_avg[ch]});
  endtask : do_meas

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  localparam logic [7:0] D_CFG [6] = '{8'h10, 8'h10, 8'h18, 8'h07, 8'hf0, 8'h03};
  localparam logic [7:0] D_RES [6] = '{8'h81, 8'h82, 8'h90, 8'hff, 8'hff, 8'h00};
  localparam int         D_CH  [6] = '{1, 1, 1, 2, 0, 2};
  logic [31:0] rd;
  logic        err;
  int          ch;

  initial begin
    ch = $urandom(38);
    clr_model();
    repeat (8) @(posedge mclk_i);
    reset_i <= 0;
    all_chk();
    // Corner cases: threshold edge, exclude/include, average as reference
    for (int i = 0; i < 6; i++) begin
      if (m_cfg[D_CH[i]] !== D_CFG[i]) set_ch(D_CH[i], D_CFG[i], 8'h80, 1);
      do_meas(D_CH[i], D_RES[i]);
    end
    do_meas(1, 8'h20);
    // Disabled channel keeps average
    set_ch(1, 8'h10, 8'h80, 0);
    do_meas(1, 8'h00);
    // Refused accesses
    rd_chk("unmapped", 8'h3e, {1'b1, 32'h0});
    apb(1, 8'h3f, 32'h55, 4'hf, rd, err);
    check("unmapped_wr", {32'h0, err}, 33'h1);
    wr(IDX_PHASE_RES, 8'h5a);
    apb(1, IDX_PHASE_REF, 32'h33, 4'h0, rd, err);
    all_chk();
    // Random traffic
    for (int it = 0; it < 40; it++) begin
      ch = $urandom_range(2, 0);
      set_ch(ch, 8'($urandom), 8'($urandom), $urandom_range(3, 0) != 0);
      for (int k = 0; k < 3; k++) begin
        if ($urandom_range(1, 0) != 0) do_meas(ch, 8'($urandom));
        else do_meas(ch, m_ref[ch] + 8'($urandom_range(16, 0)) - 8'h08);
      end
    end
    all_chk();
    // Restore defaults clears everything
    @(posedge mclk_i);
    restore <= 1;
    @(posedge mclk_i);
    restore <= 0;
    clr_model();
    all_chk();
    // Weight 4 step from a cleared average
    set_ch(1, 8'h08, 8'h00, 1);
    do_meas(1, 8'h80);
    // Reset in mid-run, then weight 32 step
    @(posedge mclk_i);
    reset_i <= 1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 0;
    clr_model();
    all_chk();
    set_ch(1, 8'h0e, 8'h00, 1);
    do_meas(1, 8'h80);
    wrap_up();
  end
endmodule : tb_top

// file: include/wakeup_compare_pkg.sv
// How it works
// - Phase config bits 7:4 are the phase threshold; larger difference raises interrupt.
// - Capacitance config bits 7:4 are the capacitance threshold; larger difference raises interrupt.
// - Phase config bit 3 clear drops triggering results from the phase average.
// - Capacitance config bit 3 clear drops triggering results from capacitance average.
// - Weight codes 00, 01, 10, 11 give newest result weights 4, 8, 16, 32.
// - Phase config bit 0 picks phase reference register or phase average.
// - Capacitance config bit 0 picks capacitance reference register or capacitance average.
// - Read-write 8-bit phase reference value at index 37h.
// - Read-write 8-bit capacitance reference value at index 3Bh.
// - Read-only amplitude average at index 34h.
// - Read-only latest amplitude result at index 35h.
// - Read-only phase average at index 38h.
// - Read-only latest phase result at index 39h.
// - Read-only capacitance average at index 3Ch.
// - Read-only latest capacitance result at index 3Dh.
// - Result and average displays read zero after reset and restore-defaults.
// - Configuration and reference registers clear on reset and restore-defaults.
// - A measurement is compared only while its wake enable bit is set.
// - Enabled amplitude result beyond amplitude threshold raises an interrupt.
package wakeup_compare_pkg;

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  localparam int CH_AMP   = 0;
  localparam int CH_PHASE = 1;
  localparam int CH_CAP   = 2;
  localparam int NCH      = 3;

  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_AMP_AVG   = 8'h34;
  localparam logic [7:0] IDX_AMP_RES   = 8'h35;
  localparam logic [7:0] IDX_PHASE_CFG = 8'h36;
  localparam logic [7:0] IDX_PHASE_REF = 8'h37;
  localparam logic [7:0] IDX_PHASE_AVG = 8'h38;
  localparam logic [7:0] IDX_PHASE_RES = 8'h39;
  localparam logic [7:0] IDX_CAP_CFG   = 8'h3a;
  localparam logic [7:0] IDX_CAP_REF   = 8'h3b;
  localparam logic [7:0] IDX_CAP_AVG   = 8'h3c;
  localparam logic [7:0] IDX_CAP_RES   = 8'h3d;
  localparam logic [7:0] IDX_WAKE_EN   = 8'h40;
  localparam logic [7:0] IDX_AMP_CFG   = 8'h41;
  localparam logic [7:0] IDX_AMP_REF   = 8'h42;

  localparam logic [7:0] CFG_IDX [NCH] = '{IDX_AMP_CFG, IDX_PHASE_CFG, IDX_CAP_CFG};
  localparam logic [7:0] REF_IDX [NCH] = '{IDX_AMP_REF, IDX_PHASE_REF, IDX_CAP_REF};
  localparam logic [7:0] AVG_IDX [NCH] = '{IDX_AMP_AVG, IDX_PHASE_AVG, IDX_CAP_AVG};
  localparam logic [7:0] RES_IDX [NCH] = '{IDX_AMP_RES, IDX_PHASE_RES, IDX_CAP_RES};

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  localparam int THR_MSB     = 7;
  localparam int THR_LSB     = 4;
  localparam int INCLUDE_BIT = 3;
  localparam int WEIGHT_HI   = 2;
  localparam int WEIGHT_LO   = 1;
  localparam int REFSEL_BIT  = 0;

  // Weight code 00 is a shift of 2, i.e. divide by 4
  localparam logic [2:0] WEIGHT_SHIFT_BASE = 3'h2;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0]  CFG_RESET  = 8'h00;
  localparam logic [7:0]  REF_RESET  = 8'h00;
  localparam logic [7:0]  DISP_RESET = 8'h00;
  localparam logic [2:0]  EN_RESET   = 3'h0;
  localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

endpackage : wakeup_compare_pkg

// file: rtl/wakeup_measurement_compare_regs.sv
module wakeup_measurement_compare_regs #(
  parameter int ADDR_W = 10
) (
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  input  wire logic              restore_defaults_i,
  // APB slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  input  wire logic [3:0]        pstrb_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // Measurement engines
  input  wire logic              amplitude_valid_i,
  input  wire logic [7:0]        amplitude_result_i,
  input  wire logic              phase_valid_i,
  input  wire logic [7:0]        phase_result_i,
  input  wire logic              capacitance_valid_i,
  input  wire logic [7:0]        capacitance_result_i,
  // Wake-up comparison events
  output logic                   amplitude_wake_irq_o,
  output logic                   phase_wake_irq_o,
  output logic                   capacitance_wake_irq_o
);
  import wakeup_compare_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]     cfg_r [NCH];
  logic [7:0]     ref_r [NCH];
  logic [7:0]     avg_r [NCH];
  logic [7:0]     res_r [NCH];
  logic [NCH-1:0] wake_en_r;
  logic [NCH-1:0] irq_r;
  logic           pready_r;
  logic           pslverr_r;
  logic [31:0]    prdata_r;

  logic [NCH-1:0] meas_valid;
  logic [7:0]     meas_result [NCH];
  logic [7:0]     cmp_ref     [NCH];
  logic [7:0]     abs_diff    [NCH];
  logic [7:0]     avg_nxt     [NCH];
  logic [NCH-1:0] trig;
  logic [NCH-1:0] compare_go;
  logic [NCH-1:0] avg_take;
  logic [NCH-1:0] cfg_wr;
  logic [NCH-1:0] ref_wr;

  assign meas_valid     = {capacitance_valid_i, phase_valid_i, amplitude_valid_i};
  assign meas_result[CH_AMP]   = amplitude_result_i;
  assign meas_result[CH_PHASE] = phase_result_i;
  assign meas_result[CH_CAP]   = capacitance_result_i;

  // ----------------------------------------------------------------
  // APB decode, one wait state
  // ----------------------------------------------------------------
  wire       clear_all = reset_i | restore_defaults_i;
  wire [7:0] reg_idx   = 8'(paddr_i[ADDR_W-1:2]);
  wire       access    = psel_i & penable_i & ~pready_r;
  wire       commit    = psel_i & penable_i & pready_r;
  wire       wr_commit = commit & pwrite_i & pstrb_i[0];
  wire       en_wr     = wr_commit & (reg_idx == IDX_WAKE_EN);

  logic       rd_hit;
  logic [7:0] rd_byte;

  always_comb begin
    rd_hit  = (reg_idx == IDX_WAKE_EN);
    rd_byte = rd_hit ? {5'h00, wake_en_r} : 8'h00;
    for (int c = 0; c < NCH; c++) begin
      if (reg_idx == CFG_IDX[c]) begin
        rd_hit  = 1'b1;
        rd_byte = cfg_r[c];
      end
      if (reg_idx == REF_IDX[c]) begin
        rd_hit  = 1'b1;
        rd_byte = ref_r[c];
      end
      if (reg_idx == AVG_IDX[c]) begin
        rd_hit  = 1'b1;
        rd_byte = avg_r[c];
      end
      if (reg_idx == RES_IDX[c]) begin
        rd_hit  = 1'b1;
        rd_byte = res_r[c];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= RDATA_IDLE;
    end else begin
      pready_r  <= access;
      pslverr_r <= access & ~rd_hit;
      prdata_r  <= (access & ~pwrite_i & rd_hit) ? {24'h000000, rd_byte} : RDATA_IDLE;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (clear_all) begin
      wake_en_r <= EN_RESET;
    end else if (en_wr) begin
      wake_en_r <= pwdata_i[NCH-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Per-channel compare and averaging
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire [3:0]        threshold = cfg_r[c][THR_MSB:THR_LSB];
    wire [1:0]        wcode     = cfg_r[c][WEIGHT_HI:WEIGHT_LO];
    wire [2:0]        wshift    = {1'b0, wcode} + WEIGHT_SHIFT_BASE;
    wire signed [8:0] step      = $signed({1'b0, meas_result[c]}) - $signed({1'b0, avg_r[c]});
    wire signed [8:0] step_w    = step >>> wshift;
    wire [8:0]        sum       = {1'b0, avg_r[c]} + step_w;

    assign cmp_ref[c]    = cfg_r[c][REFSEL_BIT] ? avg_r[c] : ref_r[c];
    assign abs_diff[c]   = (meas_result[c] >= cmp_ref[c]) ? meas_result[c] - cmp_ref[c]
                                                          : cmp_ref[c] - meas_result[c];
    assign trig[c]       = abs_diff[c] > {4'h0, threshold};
    assign compare_go[c] = meas_valid[c] & wake_en_r[c];
    assign avg_take[c]   = compare_go[c] & (~trig[c] | cfg_r[c][INCLUDE_BIT]);
    assign avg_nxt[c]    = sum[7:0];
    assign cfg_wr[c]     = wr_commit & (reg_idx == CFG_IDX[c]);
    assign ref_wr[c]     = wr_commit & (reg_idx == REF_IDX[c]);

    always_ff @(posedge mclk_i) begin
      if (clear_all) begin
        cfg_r[c] <= CFG_RESET;
        ref_r[c] <= REF_RESET;
        avg_r[c] <= DISP_RESET;
        res_r[c] <= DISP_RESET;
        irq_r[c] <= 1'b0;
      end else begin
        if (cfg_wr[c]) begin
          cfg_r[c] <= pwdata_i[7:0];
        end
        if (ref_wr[c]) begin
          ref_r[c] <= pwdata_i[7:0];
        end
        if (meas_valid[c]) begin
          res_r[c] <= meas_result[c];
        end
        if (avg_take[c]) begin
          avg_r[c] <= avg_nxt[c];
        end
        irq_r[c] <= compare_go[c] & trig[c];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata_o               = prdata_r;
  assign pready_o               = pready_r;
  assign pslverr_o              = pslverr_r;
  assign amplitude_wake_irq_o   = irq_r[CH_AMP];
  assign phase_wake_irq_o       = irq_r[CH_PHASE];
  assign capacitance_wake_irq_o = irq_r[CH_CAP];

  // ----------------------------------------------------------------
  // Named fields
  // ----------------------------------------------------------------
  wire [3:0] phase_threshold                     = cfg_r[CH_PHASE][THR_MSB:THR_LSB];
  wire [3:0] capacitance_threshold               = cfg_r[CH_CAP][THR_MSB:THR_LSB];
  wire [3:0] amplitude_threshold                 = cfg_r[CH_AMP][THR_MSB:THR_LSB];
  wire       phase_average_include_trigger       = cfg_r[CH_PHASE][INCLUDE_BIT];
  wire       capacitance_average_include_trigger = cfg_r[CH_CAP][INCLUDE_BIT];
  wire       phase_reference_select              = cfg_r[CH_PHASE][REFSEL_BIT];
  wire       capacitance_reference_select        = cfg_r[CH_CAP][REFSEL_BIT];
  wire [1:0] phase_weight = {cfg_r[CH_PHASE][WEIGHT_HI], cfg_r[CH_PHASE][WEIGHT_LO]};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (clear_all);

  sequence s_phase_go;
    phase_valid_i && wake_en_r[CH_PHASE];
  endsequence

  sequence s_cap_go;
    capacitance_valid_i && wake_en_r[CH_CAP];
  endsequence

  sequence s_phase_ref_write;
    psel_i && penable_i && pready_r && pwrite_i && pstrb_i[0] && reg_idx == IDX_PHASE_REF;
  endsequence

  property p_phase_threshold;
    s_phase_go ##0 (abs_diff[CH_PHASE] > {4'h0, phase_threshold}) |=> phase_wake_irq_o;
  endproperty
  a_phase_threshold: assert property (p_phase_threshold)
    else $error("phase beyond threshold gave no event");

  property p_phase_quiet;
    s_phase_go ##0 (abs_diff[CH_PHASE] <= {4'h0, phase_threshold}) |=> !phase_wake_irq_o;
  endproperty
  a_phase_quiet: assert property (p_phase_quiet)
    else $error("phase within threshold gave an event");

  property p_cap_threshold;
    s_cap_go |=> (capacitance_wake_irq_o == ($past(abs_diff[CH_CAP]) > {4'h0, $past(capacitance_threshold)}));
  endproperty
  a_cap_threshold: assert property (p_cap_threshold)
    else $error("capacitance event disagrees with threshold");

  property p_phase_exclude;
    s_phase_go ##0 trig[CH_PHASE] ##0 !phase_average_include_trigger |=> $stable(avg_r[CH_PHASE]);
  endproperty
  a_phase_exclude: assert property (p_phase_exclude)
    else $error("excluded phase result moved the average");

  property p_cap_exclude;
    s_cap_go ##0 trig[CH_CAP] ##0 !capacitance_average_include_trigger |=> $stable(avg_r[CH_CAP]);
  endproperty
  a_cap_exclude: assert property (p_cap_exclude)
    else $error("excluded capacitance result moved the average");

  property p_weight_four;
    s_phase_go ##0 (phase_weight == 2'h0 && avg_r[CH_PHASE] == 8'h00 && phase_result_i == 8'h80
                    && phase_average_include_trigger) |=> avg_r[CH_PHASE] == 8'h20;
  endproperty
  a_weight_four: assert property (p_weight_four)
    else $error("weight 4 average step wrong");

  property p_weight_32;
    s_phase_go ##0 (phase_weight == 2'h3 && avg_r[CH_PHASE] == 8'h00 && phase_result_i == 8'h80
                    && phase_average_include_trigger) |=> avg_r[CH_PHASE] == 8'h04;
  endproperty
  a_weight_32: assert property (p_weight_32)
    else $error("weight 32 average step wrong");

  property p_phase_refsel;
    s_phase_go ##0 (phase_result_i == (phase_reference_select ? avg_r[CH_PHASE] : ref_r[CH_PHASE]))
      |=> !phase_wake_irq_o;
  endproperty
  a_phase_refsel: assert property (p_phase_refsel)
    else $error("phase compared against wrong reference");

  property p_cap_refsel;
    s_cap_go ##0 (capacitance_result_i == (capacitance_reference_select ? avg_r[CH_CAP] : ref_r[CH_CAP]))
      |=> !capacitance_wake_irq_o;
  endproperty
  a_cap_refsel: assert property (p_cap_refsel)
    else $error("capacitance compared against wrong reference");

  property p_phase_ref_write;
    s_phase_ref_write |=> ref_r[CH_PHASE] == $past(pwdata_i[7:0]);
  endproperty
  a_phase_ref_write: assert property (p_phase_ref_write)
    else $error("phase reference write lost");

  property p_result_display;
    phase_valid_i |=> res_r[CH_PHASE] == $past(phase_result_i);
  endproperty
  a_result_display: assert property (p_result_display)
    else $error("phase result display not updated");

  property p_disabled_silent;
    (meas_valid & ~wake_en_r) == meas_valid && meas_valid != 3'h0 |=> irq_r == 3'h0;
  endproperty
  a_disabled_silent: assert property (p_disabled_silent)
    else $error("disabled channel raised an event");

  property p_amp_threshold;
    amplitude_valid_i && wake_en_r[CH_AMP] && abs_diff[CH_AMP] > {4'h0, amplitude_threshold}
      |=> amplitude_wake_irq_o;
  endproperty
  a_amp_threshold: assert property (p_amp_threshold)
    else $error("amplitude beyond threshold gave no event");

  property p_restore_clears;
    @(posedge mclk_i) disable iff (reset_i)
    restore_defaults_i |=> cfg_r[CH_PHASE] == 8'h00 && ref_r[CH_CAP] == 8'h00
                           && avg_r[CH_AMP] == 8'h00 && res_r[CH_PHASE] == 8'h00;
  endproperty
  a_restore_clears: assert property (p_restore_clears)
    else $error("restore-defaults left a register set");

  sequence s_apb_access;
    psel_i && penable_i && !pready_r;
  endsequence

  property p_one_wait;
    s_apb_access |=> pready_o;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("access phase not answered after one wait state");

  property p_ready_pulse;
    pready_o |=> !pready_o;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready stood longer than one cycle");

  property p_error_with_ready;
    pslverr_o |-> pready_o;
  endproperty
  a_error_with_ready: assert property (p_error_with_ready)
    else $error("error flag without ready");

  property p_wake_en_write;
    en_wr |=> wake_en_r == $past(pwdata_i[NCH-1:0]);
  endproperty
  a_wake_en_write: assert property (p_wake_en_write)
    else $error("wake enable write lost");

  property p_cap_ref_write;
    psel_i && penable_i && pready_r && pwrite_i && pstrb_i[0] && reg_idx == IDX_CAP_REF
      |=> ref_r[CH_CAP] == $past(pwdata_i[7:0]);
  endproperty
  a_cap_ref_write: assert property (p_cap_ref_write)
    else $error("capacitance reference write lost");

  property p_cap_quiet;
    s_cap_go ##0 (abs_diff[CH_CAP] <= {4'h0, capacitance_threshold}) |=> !capacitance_wake_irq_o;
  endproperty
  a_cap_quiet: assert property (p_cap_quiet)
    else $error("capacitance within threshold gave an event");

  property p_amp_quiet;
    amplitude_valid_i && wake_en_r[CH_AMP] && abs_diff[CH_AMP] <= {4'h0, amplitude_threshold}
      |=> !amplitude_wake_irq_o;
  endproperty
  a_amp_quiet: assert property (p_amp_quiet)
    else $error("amplitude within threshold gave an event");

  property p_amp_result_display;
    amplitude_valid_i |=> res_r[CH_AMP] == $past(amplitude_result_i);
  endproperty
  a_amp_result_display: assert property (p_amp_result_display)
    else $error("amplitude result display not updated");

  property p_cap_result_display;
    capacitance_valid_i |=> res_r[CH_CAP] == $past(capacitance_result_i);
  endproperty
  a_cap_result_display: assert property (p_cap_result_display)
    else $error("capacitance result display not updated");

  property p_disabled_keeps_average;
    phase_valid_i && !wake_en_r[CH_PHASE] |=> $stable(avg_r[CH_PHASE]);
  endproperty
  a_disabled_keeps_average: assert property (p_disabled_keeps_average)
    else $error("disabled phase channel moved the average");

  property p_no_valid_quiet;
    meas_valid == 3'h0 |=> irq_r == 3'h0;
  endproperty
  a_no_valid_quiet: assert property (p_no_valid_quiet)
    else $error("event raised without a measurement");

  property p_restore_rest;
    @(posedge mclk_i) disable iff (reset_i)
    restore_defaults_i |=> cfg_r[CH_CAP] == 8'h00 && cfg_r[CH_AMP] == 8'h00 && ref_r[CH_PHASE] == 8'h00
                           && avg_r[CH_PHASE] == 8'h00 && avg_r[CH_CAP] == 8'h00 && res_r[CH_CAP] == 8'h00
                           && wake_en_r == 3'h0;
  endproperty
  a_restore_rest: assert property (p_restore_rest)
    else $error("restore-defaults left another register set");

endmodule : wakeup_measurement_compare_regs
